// >>> trw_pkg.sv
// trw_pkg: constants and types for the timer rollover / wake block
// assumes: single 25 MHz core clock, synchronous active-high reset
package trw_pkg;

    localparam int            TRW_CNT_W       = 16;
    localparam logic [15:0]   TRW_CNT_MAX     = 16'hffff;
    localparam logic [15:0]   TRW_CNT_RST     = 16'h0000;
    localparam int            TRW_CS_W        = 2;
    localparam logic [1:0]    TRW_CS_RST      = 2'h0;
    localparam logic [1:0]    TRW_CS_SYSCLK   = 2'h0;
    localparam logic [1:0]    TRW_CS_EXTCLK   = 2'h2;
    localparam int            TRW_ALT_W       = 2;
    localparam logic [1:0]    TRW_ALT_RST     = 2'h0;

    typedef enum logic [1:0] {
        TRW_RUN,
        TRW_SLEEP,
        TRW_WAKE
    } trw_pwr_e;

    typedef struct packed {
        logic        flag;
        logic [1:0]  alt;
        trw_pwr_e    pwr;
        logic        wake;
        logic        vector;
        logic        ext_q;
    } trw_state_s;

endpackage : trw_pkg

// >>> trw_if.sv
// trw_if: increment request and wrap indication between top and counter
// assumes: both ends on I_CORE_CLK
`timescale 1ns/1ns
interface trw_if;
    logic        inc;
    logic        load_lo;
    logic        load_hi;
    logic [7:0]  wdata;
    logic [15:0] count;
    logic        wrap;

    modport ctl (output inc, output load_lo, output load_hi, output wdata,
                 input count, input wrap);
    modport cnt (input inc, input load_lo, input load_hi, input wdata,
                 output count, output wrap);
endinterface : trw_if

// >>> trw_counter.sv
// trw_counter: 16-bit count pair with byte loads and wrap pulse
// assumes: loads are single-cycle strobes on I_CORE_CLK; inc counts once per enabled cycle it is high
`timescale 1ns/1ns
module trw_counter
    import trw_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_ce,
    // control
    trw_if.cnt        bus
);
    typedef struct packed {
        logic [15:0] count;
        logic        wrap;
    } trw_cnt_s;

    trw_cnt_s cnt_r;
    trw_cnt_s cnt_nxt;

    always_comb
    begin
        cnt_nxt      = cnt_r;
        cnt_nxt.wrap = 1'b0;
        if (bus.load_lo)
        begin
            cnt_nxt.count[7:0] = bus.wdata;
        end
        else if (bus.load_hi)
        begin
            cnt_nxt.count[15:8] = bus.wdata;
        end
        else if (bus.inc)
        begin
            cnt_nxt.count = cnt_r.count + 16'h0001;
            cnt_nxt.wrap  = (cnt_r.count == TRW_CNT_MAX);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cnt_r.count <= TRW_CNT_RST;
            cnt_r.wrap  <= 1'b0;
        end
        else if (i_ce)
        begin
            cnt_r <= cnt_nxt;
        end
    end

    assign bus.count = cnt_r.count;
    assign bus.wrap  = cnt_r.wrap;

    a_wrap_to_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && bus.inc && !bus.load_lo && !bus.load_hi && cnt_r.count == TRW_CNT_MAX
        |=> cnt_r.count == 16'h0000 && cnt_r.wrap)
        else $error("counter did not wrap to zero");

    a_load_no_wrap: assert property (@(posedge i_clk) disable iff (i_reset)
        i_ce && (bus.load_lo || bus.load_hi) |=> !cnt_r.wrap)
        else $error("byte load produced a wrap");

endmodule : trw_counter

// >>> trw_top.sv
// trw_top: timer overflow flag, interrupt gating, sleep wake and pin select
// assumes: all inputs synchronous to I_CORE_CLK; ext tick sampled here
`timescale 1ns/1ns
module trw_top
    import trw_pkg::*;
(
    // clock and reset
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RESET,
    input  wire logic        I_CE,
    // timer control
    input  wire logic        I_TIMER_RUN,
    input  wire logic        I_SYNC_CONTROL,
    input  wire logic [1:0]  I_CLOCK_SOURCE_SELECT,
    input  wire logic        I_OSC_ENABLE,
    // interrupt enables
    input  wire logic        I_OVERFLOW_IRQ_ENABLE,
    input  wire logic        I_PERIPHERAL_IRQ_ENABLE,
    input  wire logic        I_GLOBAL_IRQ_ENABLE,
    // software access to count bytes and flag
    input  wire logic        I_WR_COUNT_LOW_BYTE,
    input  wire logic        I_WR_COUNT_HIGH_BYTE,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic        I_CLR_OVERFLOW_IRQ_FLAG,
    // alternate pin select
    input  wire logic        I_WR_ALT_PIN_SELECT,
    input  wire logic [1:0]  I_ALT_PIN_SELECT,
    // sleep
    input  wire logic        I_SLEEP_REQ,
    // count sources (ext tick from pin mux, both locations)
    input  wire logic        I_EXT_CLK_PIN_DEF,
    input  wire logic        I_EXT_CLK_PIN_ALT,
    // status
    output logic [7:0]       O_COUNT_LOW_BYTE,
    output logic [7:0]       O_COUNT_HIGH_BYTE,
    output logic             O_OVERFLOW_IRQ_FLAG,
    output logic             O_IRQ,
    output logic [1:0]       O_ALT_PIN_SELECT,
    output logic             O_OSC_RUN,
    output logic             O_ASLEEP,
    output logic             O_WAKE,
    output logic             O_TAKE_VECTOR
);
    trw_state_s st_r;
    trw_state_s st_nxt;
    logic       ext_pin;
    logic       ext_edge;
    logic       inc;
    logic       asleep;

    trw_if u_if ();

    trw_counter trw_counter_inst (
        .i_clk   (I_CORE_CLK),
        .i_reset (I_RESET),
        .i_ce    (I_CE),
        .bus     (u_if.cnt)
    );

    // ------------------------------------------------------------
    // count source and increment
    // ------------------------------------------------------------
    assign ext_pin  = st_r.alt[0] ? I_EXT_CLK_PIN_ALT : I_EXT_CLK_PIN_DEF;
    assign ext_edge = ext_pin && !st_r.ext_q;
    assign asleep   = (st_r.pwr == TRW_SLEEP);

    always_comb
    begin
        inc = 1'b0;
        if (I_TIMER_RUN)
        begin
            if (asleep)
            begin
                inc = (I_CLOCK_SOURCE_SELECT == TRW_CS_EXTCLK) && I_SYNC_CONTROL
                      && ext_edge;
            end
            else if (I_CLOCK_SOURCE_SELECT == TRW_CS_SYSCLK)
            begin
                inc = 1'b1;
            end
            else
            begin
                inc = ext_edge;
            end
        end
    end

    assign u_if.inc     = inc;
    assign u_if.load_lo = I_WR_COUNT_LOW_BYTE;
    assign u_if.load_hi = I_WR_COUNT_HIGH_BYTE;
    assign u_if.wdata   = I_WDATA;

    // ------------------------------------------------------------
    // state update
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.ext_q  = ext_pin;
        st_nxt.wake   = 1'b0;
        st_nxt.vector = 1'b0;
        // set wins over a same-cycle software clear
        if (u_if.wrap)
        begin
            st_nxt.flag = 1'b1;
        end
        else if (I_CLR_OVERFLOW_IRQ_FLAG)
        begin
            st_nxt.flag = 1'b0;
        end
        if (I_WR_ALT_PIN_SELECT)
        begin
            st_nxt.alt = I_ALT_PIN_SELECT;
        end
        case (st_r.pwr)
            TRW_RUN:
            begin
                if (I_SLEEP_REQ)
                begin
                    st_nxt.pwr = TRW_SLEEP;
                end
            end
            TRW_SLEEP:
            begin
                if (u_if.wrap && I_TIMER_RUN && I_OVERFLOW_IRQ_ENABLE
                    && I_PERIPHERAL_IRQ_ENABLE)
                begin
                    st_nxt.pwr    = TRW_WAKE;
                    st_nxt.wake   = 1'b1;
                    st_nxt.vector = I_GLOBAL_IRQ_ENABLE;
                end
            end
            TRW_WAKE:
            begin
                st_nxt.pwr = TRW_RUN;
            end
            default:
            begin
                st_nxt.pwr = TRW_RUN;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RESET)
        begin
            st_r.flag   <= 1'b0;
            st_r.alt    <= TRW_ALT_RST;
            st_r.pwr    <= TRW_RUN;
            st_r.wake   <= 1'b0;
            st_r.vector <= 1'b0;
            st_r.ext_q  <= 1'b0;
        end
        else if (I_CE)
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_COUNT_LOW_BYTE    = u_if.count[7:0];
    assign O_COUNT_HIGH_BYTE   = u_if.count[15:8];
    assign O_OVERFLOW_IRQ_FLAG = st_r.flag;
    assign O_IRQ = st_r.flag && I_TIMER_RUN && I_OVERFLOW_IRQ_ENABLE
                   && I_PERIPHERAL_IRQ_ENABLE && I_GLOBAL_IRQ_ENABLE;
    assign O_ALT_PIN_SELECT    = st_r.alt;
    assign O_OSC_RUN           = I_OSC_ENABLE;
    assign O_ASLEEP            = asleep;
    assign O_WAKE              = st_r.wake;
    assign O_TAKE_VECTOR       = st_r.vector;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_sleep_wrap;
        asleep && u_if.wrap && I_TIMER_RUN && I_OVERFLOW_IRQ_ENABLE
        && I_PERIPHERAL_IRQ_ENABLE && I_CE;
    endsequence

    a_flag_on_wrap: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        I_CE && u_if.wrap |=> O_OVERFLOW_IRQ_FLAG)
        else $error("wrap did not set flag");

    a_flag_holds: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        O_OVERFLOW_IRQ_FLAG && !I_CLR_OVERFLOW_IRQ_FLAG |=> O_OVERFLOW_IRQ_FLAG)
        else $error("flag dropped without clear");

    a_irq_gating: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        O_IRQ |-> O_OVERFLOW_IRQ_FLAG && I_TIMER_RUN && I_GLOBAL_IRQ_ENABLE
        && I_PERIPHERAL_IRQ_ENABLE && I_OVERFLOW_IRQ_ENABLE)
        else $error("interrupt raised without all enables");

    a_sleep_count: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        asleep && I_CLOCK_SOURCE_SELECT != TRW_CS_EXTCLK |-> !inc)
        else $error("counted in sleep outside async mode");

    a_wake_on_wrap: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        s_sleep_wrap |=> O_WAKE && !O_ASLEEP ##1 !O_WAKE)
        else $error("no wake after sleep overflow");

    a_vector_gie: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        s_sleep_wrap |=> O_TAKE_VECTOR == $past(I_GLOBAL_IRQ_ENABLE))
        else $error("vector decision wrong after wake");

    a_osc_sleep: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
        asleep && I_OSC_ENABLE |-> O_OSC_RUN)
        else $error("oscillator stopped in sleep");

    a_alt_reset: assert property (@(posedge I_CORE_CLK)
        I_RESET |=> O_ALT_PIN_SELECT == TRW_ALT_RST)
        else $error("pin select not restored on reset");

endmodule : trw_top

// >>> trw_ext_src.sv
// trw_ext_src: external count clock source for the timer input pin
// assumes: toggles on the core clock only while enabled, else held low
`timescale 1ns/1ns
module trw_ext_src
(
    // clock and control
    input  wire logic i_clk,
    input  wire logic i_en,
    // count pin
    output logic      o_pin
);
    initial o_pin = 1'b0;
    // one rising edge every two core cycles while enabled, held low when disabled
    always @(posedge i_clk)
    begin
        o_pin <= i_en ? ~o_pin : 1'b0;
    end
endmodule : trw_ext_src

// >>> trw_top_tb.sv
// trw_top_tb: sequence tests for the timer rollover / wake block
// assumes: trw_pkg, trw_if, trw_counter, trw_top and trw_ext_src compiled
`timescale 1ns/1ns
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module trw_top_tb;
    import trw_pkg::*;
    logic       clk = 0, rst = 1, run = 0, sync = 0, osc = 0;
    logic       oie = 0, pie = 0, global_irq_enable = 0, wlo = 0, whi = 0, clr = 0;
    logic       walt = 0, slp = 0, en_d = 0, en_a = 0, ce = 1;
    logic [1:0] src = 2'h0, alt = 2'h0, o_alt;
    logic [7:0] wd = 8'h00, lo, hi;
    logic       p_def, p_alt, flag, irq, oscr, asl, wake, vec;
    int         bad_count = 0, cmp_count = 0;
    // ----------------------------------------
    // clock, partner and design
    // ----------------------------------------
    initial forever #20 clk = ~clk;
    trw_ext_src src_d (.i_clk(clk), .i_en(en_d), .o_pin(p_def));
    trw_ext_src src_a (.i_clk(clk), .i_en(en_a), .o_pin(p_alt));
    trw_top trw_top_inst (.I_CORE_CLK(clk), .I_RESET(rst), .I_CE(ce),
        .I_TIMER_RUN(run), .I_SYNC_CONTROL(sync), .I_CLOCK_SOURCE_SELECT(src),
        .I_OSC_ENABLE(osc), .I_OVERFLOW_IRQ_ENABLE(oie),
        .I_PERIPHERAL_IRQ_ENABLE(pie), .I_GLOBAL_IRQ_ENABLE(global_irq_enable),
        .I_WR_COUNT_LOW_BYTE(wlo), .I_WR_COUNT_HIGH_BYTE(whi), .I_WDATA(wd),
        .I_CLR_OVERFLOW_IRQ_FLAG(clr), .I_WR_ALT_PIN_SELECT(walt),
        .I_ALT_PIN_SELECT(alt), .I_SLEEP_REQ(slp), .I_EXT_CLK_PIN_DEF(p_def),
        .I_EXT_CLK_PIN_ALT(p_alt), .O_COUNT_LOW_BYTE(lo), .O_COUNT_HIGH_BYTE(hi),
        .O_OVERFLOW_IRQ_FLAG(flag), .O_IRQ(irq), .O_ALT_PIN_SELECT(o_alt),
        .O_OSC_RUN(oscr), .O_ASLEEP(asl), .O_WAKE(wake), .O_TAKE_VECTOR(vec));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr_cnt(input logic [15:0] v);
        @(posedge clk);
        wlo <= 1'b1;
        wd  <= v[7:0];
        @(posedge clk);
        wlo <= 1'b0;
        whi <= 1'b1;
        wd  <= v[15:8];
        @(posedge clk);
        whi <= 1'b0;
    endtask : wr_cnt
    task automatic pulse_clr;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask : pulse_clr
    task automatic wr_alt(input logic [1:0] v);
        @(posedge clk);
        walt <= 1'b1;
        alt  <= v;
        @(posedge clk);
        walt <= 1'b0;
    endtask : wr_alt
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        @(negedge clk);
    endtask : do_reset
    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        do_reset();
        `CHK("count", 16'h0000, {hi, lo})
        `CHK("alt", 2'h0, o_alt)
        // wrap from ffff, byte writes alone leave the flag clear
        wr_cnt(16'hffff);
        @(negedge clk);
        `CHK("flag_wr", 1'b0, flag)
        `CHK("count_wr", 16'hffff, {hi, lo})
        @(posedge clk);
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(negedge clk);
        `CHK("count_wrap", 16'h0000, {hi, lo})
        `CHK("flag_wrap", 1'b1, flag)
        $display("test wrap done");
        // interrupt gating over every enable combination, idle ext source
        @(posedge clk);
        src <= 2'h1;
        for (int k = 0; k < 16; k++)
        begin
            @(posedge clk);
            {run, oie, pie, global_irq_enable} <= 4'(k);
            @(negedge clk);
            `CHK("irq", (k == 15), irq)
        end
        `CHK("flag_held", 1'b1, flag)
        pulse_clr();
        @(negedge clk);
        `CHK("flag_clr", 1'b0, flag)
        `CHK("irq_clr", 1'b0, irq)
        $display("test irq done");
        // sleep wake, default pin without global enable, alternate pin with it
        for (int g = 0; g < 2; g++)
        begin
            wr_alt(2'(g));
            @(posedge clk);
            {run, oie, pie, global_irq_enable, sync, osc, src} <= {4'(14 + g), 2'h3, 2'h2};
            wr_cnt(16'hfffc);
            pulse_clr();
            @(posedge clk);
            slp <= 1'b1;
            @(posedge clk);
            slp <= 1'b0;
            en_d <= (g == 0);
            en_a <= (g == 1);
            @(negedge clk);
            `CHK("asleep", 1'b1, asl)
            `CHK("osc", 1'b1, oscr)
            `CHK("alt_sel", 2'(g), o_alt)
            for (int w = 0; w < 100 && wake !== 1'b1; w++)
                @(negedge clk);
            `CHK("wake", 1'b1, wake)
            `CHK("vector", 1'(g), vec)
            `CHK("awake", 1'b0, asl)
            `CHK("flag_sleep", 1'b1, flag)
            if (wake !== 1'b1)
                close_out();
            @(negedge clk);
            `CHK("wake_pulse", 1'b0, wake)
            @(posedge clk);
            {en_d, en_a} <= 2'h0;
            pulse_clr();
        end
        $display("test wake done");
        // clock enable low freezes the count
        @(posedge clk);
        {src, sync, run} <= {2'h0, 1'b0, 1'b0};
        wr_cnt(16'h00f0);
        @(posedge clk);
        run <= 1'b1;
        ce  <= 1'b0;
        cyc(3);
        @(negedge clk);
        `CHK("ce_hold", 16'h00f0, {hi, lo})
        @(posedge clk);
        ce <= 1'b1;
        cyc(1);
        @(negedge clk);
        `CHK("ce_run", 16'h00f1, {hi, lo})
        // internal source stops in sleep, sync off keeps the oscillator
        @(posedge clk);
        run <= 1'b0;
        wr_cnt(16'h1234);
        @(posedge clk);
        slp <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
        run <= 1'b1;
        @(negedge clk);
        `CHK("osc_nosync", 1'b1, oscr)
        cyc(5);
        @(negedge clk);
        `CHK("sleep_hold", 16'h1234, {hi, lo})
        `CHK("still_asleep", 1'b1, asl)
        do_reset();
        `CHK("alt_rst", 2'h0, o_alt)
        `CHK("asleep_rst", 1'b0, asl)
        $display("test sleep hold done");
        close_out();
    end
    initial
    begin
        cyc(20000);
        bad_count++;
        close_out();
    end
endmodule : trw_top_tb
